// [logic/cpu_instr_timing.sv]
`default_nettype none
module cpu_instr_timing (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic REQ_VALID_I,
    input wire tim_pkg::req_t REQ_I,
    output logic REQ_READY_O,
    output logic BUSY_O,
    output logic RD_CYCLE_O,
    output logic WR_CYCLE_O,
    output logic DONE_O,
    output logic ERR_O,
    output tim_pkg::cost_t COST_O
);
    localparam int CW = tim_pkg::CLK_W;
    localparam int BW = tim_pkg::BUS_W;

    function automatic tim_pkg::cost_t mk(input logic [CW-1:0] clk,
                                          input logic [BW-1:0] rd,
                                          input logic [BW-1:0] wr);
        tim_pkg::cost_t c;
        c.ok = 1'b1;
        c.clk = clk;
        c.rd = rd;
        c.wr = wr;
        return c;
    endfunction : mk

    function automatic tim_pkg::cost_t entry_cost(input tim_pkg::req_t q);
        tim_pkg::cost_t c;
        logic add_ea;
        logic [CW-1:0] n_clk;
        logic [BW-1:0] n_bus;
        logic [CW-1:0] step_c;
        logic [BW-1:0] step_b;
        c = '0;
        add_ea = 1'b0;
        n_clk = CW'(q.n);
        n_bus = BW'(q.n);
        step_c = q.long_sz ? tim_pkg::T8 : tim_pkg::T4;
        step_b = q.long_sz ? tim_pkg::B2 : tim_pkg::B1;
        case (q.op)
            tim_pkg::OP_ZERO_FILL, tim_pkg::OP_ARITH_COMPL,
            tim_pkg::OP_COMPL_EXT, tim_pkg::OP_INVERT: begin
                if (!q.mem) begin
                    c = mk(q.long_sz ? tim_pkg::T6 : tim_pkg::T4, tim_pkg::B1, tim_pkg::B0);
                end else if (q.long_sz) begin
                    c = mk(tim_pkg::T12, tim_pkg::B1, tim_pkg::B2);
                end else begin
                    c = mk(tim_pkg::T8, tim_pkg::B1, tim_pkg::B1);
                end
                add_ea = q.mem;
            end
            tim_pkg::OP_DEC_NEGATE: begin
                c = q.mem ? mk(tim_pkg::T8, tim_pkg::B1, tim_pkg::B1)
                          : mk(tim_pkg::T6, tim_pkg::B1, tim_pkg::B0);
                add_ea = q.mem;
            end
            tim_pkg::OP_COND_SET: begin
                if (q.mem) begin
                    c = mk(tim_pkg::T8, tim_pkg::B1, tim_pkg::B1);
                end else begin
                    c = mk(q.cond ? tim_pkg::T6 : tim_pkg::T4, tim_pkg::B1, tim_pkg::B0);
                end
                add_ea = q.mem;
            end
            tim_pkg::OP_PROBE_MARK: begin
                c = q.mem ? mk(tim_pkg::T10, tim_pkg::B1, tim_pkg::B1)
                          : mk(tim_pkg::T4, tim_pkg::B1, tim_pkg::B0);
                add_ea = q.mem;
            end
            tim_pkg::OP_CMP_ZERO: begin
                c = mk(tim_pkg::T4, tim_pkg::B1, tim_pkg::B0);
                add_ea = q.mem;
            end
            tim_pkg::OP_SHIFT_ROTATE: begin
                if (!q.mem) begin
                    c = mk((q.long_sz ? tim_pkg::T8 : tim_pkg::T6) + n_clk * tim_pkg::STEP2,
                           tim_pkg::B1, tim_pkg::B0);
                end else if (!q.long_sz) begin
                    c = mk(tim_pkg::T8, tim_pkg::B1, tim_pkg::B1);
                end
                add_ea = q.mem;
            end
            tim_pkg::OP_BIT_TOGGLE, tim_pkg::OP_BIT_SET, tim_pkg::OP_BIT_RESET: begin
                if (q.mem) begin
                    c = q.static_bit ? mk(tim_pkg::T12, tim_pkg::B2, tim_pkg::B1)
                                     : mk(tim_pkg::T8, tim_pkg::B1, tim_pkg::B1);
                end else begin
                    c = mk(q.op == tim_pkg::OP_BIT_RESET ? tim_pkg::T10 : tim_pkg::T8,
                           tim_pkg::B1, tim_pkg::B0);
                    if (q.static_bit) begin
                        c.clk = c.clk + tim_pkg::T4;
                        c.rd = c.rd + tim_pkg::B1;
                    end
                end
                add_ea = q.mem;
            end
            tim_pkg::OP_BIT_PROBE: begin
                if (q.mem) begin
                    c = q.static_bit ? mk(tim_pkg::T8, tim_pkg::B2, tim_pkg::B0)
                                     : mk(tim_pkg::T4, tim_pkg::B1, tim_pkg::B0);
                end else begin
                    c = q.static_bit ? mk(tim_pkg::T10, tim_pkg::B2, tim_pkg::B0)
                                     : mk(tim_pkg::T6, tim_pkg::B1, tim_pkg::B0);
                end
                add_ea = q.mem;
            end
            tim_pkg::OP_COND_BRANCH: begin
                if (q.cond) begin
                    c = mk(tim_pkg::T10, tim_pkg::B2, tim_pkg::B0);
                end else if (q.word_disp) begin
                    c = mk(tim_pkg::T12, tim_pkg::B2, tim_pkg::B0);
                end else begin
                    c = mk(tim_pkg::T8, tim_pkg::B1, tim_pkg::B0);
                end
            end
            tim_pkg::OP_ALWAYS_JUMP: c = mk(tim_pkg::T10, tim_pkg::B2, tim_pkg::B0);
            tim_pkg::OP_CALL_REL: c = mk(tim_pkg::T18, tim_pkg::B2, tim_pkg::B2);
            tim_pkg::OP_DEC_LOOP: begin
                if (q.cond) begin
                    c = mk(tim_pkg::T12, tim_pkg::B2, tim_pkg::B0);
                end else if (q.expired) begin
                    c = mk(tim_pkg::T14, tim_pkg::B3, tim_pkg::B0);
                end else begin
                    c = mk(tim_pkg::T10, tim_pkg::B2, tim_pkg::B0);
                end
            end
            tim_pkg::OP_TRANSFER, tim_pkg::OP_CALL_EA: begin
                case (q.ea)
                    tim_pkg::EA_IND: c = mk(tim_pkg::T8, tim_pkg::B2, tim_pkg::B0);
                    tim_pkg::EA_DISP: c = mk(tim_pkg::T10, tim_pkg::B2, tim_pkg::B0);
                    tim_pkg::EA_ABSL: c = mk(tim_pkg::T12, tim_pkg::B3, tim_pkg::B0);
                    default: c = '0;
                endcase
                if (c.ok && q.op == tim_pkg::OP_CALL_EA) begin
                    c.clk = c.clk + tim_pkg::T8;
                    c.wr = tim_pkg::B2;
                end
            end
            tim_pkg::OP_LOAD_EA, tim_pkg::OP_PUSH_EA: begin
                case (q.ea)
                    tim_pkg::EA_IND: c = mk(tim_pkg::T4, tim_pkg::B1, tim_pkg::B0);
                    tim_pkg::EA_DISP: c = mk(tim_pkg::T8, tim_pkg::B2, tim_pkg::B0);
                    tim_pkg::EA_ABSL: c = mk(tim_pkg::T12, tim_pkg::B3, tim_pkg::B0);
                    default: c = '0;
                endcase
                if (c.ok && q.op == tim_pkg::OP_PUSH_EA) begin
                    c.clk = c.clk + tim_pkg::T8;
                    c.wr = tim_pkg::B2;
                end
            end
            tim_pkg::OP_MULTI_LOAD: begin
                case (q.ea)
                    tim_pkg::EA_IND, tim_pkg::EA_POSTINC:
                        c = mk(tim_pkg::T12 + n_clk * step_c,
                               tim_pkg::B3 + n_bus * step_b, tim_pkg::B0);
                    tim_pkg::EA_DISP:
                        c = mk(tim_pkg::T16 + n_clk * step_c,
                               tim_pkg::B4 + n_bus * step_b, tim_pkg::B0);
                    tim_pkg::EA_ABSL:
                        c = mk(tim_pkg::T20 + n_clk * step_c,
                               tim_pkg::B5 + n_bus * step_b, tim_pkg::B0);
                    default: c = '0;
                endcase
            end
            tim_pkg::OP_MULTI_STORE: begin
                case (q.ea)
                    tim_pkg::EA_IND, tim_pkg::EA_PREDEC:
                        c = mk(tim_pkg::T8 + n_clk * step_c, tim_pkg::B2, n_bus * step_b);
                    tim_pkg::EA_DISP:
                        c = mk(tim_pkg::T12 + n_clk * step_c, tim_pkg::B3, n_bus * step_b);
                    tim_pkg::EA_ABSL:
                        c = mk(tim_pkg::T16 + n_clk * step_c, tim_pkg::B4, n_bus * step_b);
                    default: c = '0;
                endcase
            end
            tim_pkg::OP_ADD_EXT, tim_pkg::OP_SUB_EXT: begin
                if (!q.mem) begin
                    c = mk(q.long_sz ? tim_pkg::T8 : tim_pkg::T4, tim_pkg::B1, tim_pkg::B0);
                end else if (q.long_sz) begin
                    c = mk(tim_pkg::T30, tim_pkg::B5, tim_pkg::B2);
                end else begin
                    c = mk(tim_pkg::T18, tim_pkg::B3, tim_pkg::B1);
                end
            end
            tim_pkg::OP_PAIR_CMP: begin
                if (q.mem) begin
                    c = q.long_sz ? mk(tim_pkg::T20, tim_pkg::B5, tim_pkg::B0)
                                  : mk(tim_pkg::T12, tim_pkg::B3, tim_pkg::B0);
                end
            end
            tim_pkg::OP_DEC_ADD, tim_pkg::OP_DEC_SUB: begin
                c = q.mem ? mk(tim_pkg::T18, tim_pkg::B3, tim_pkg::B1)
                          : mk(tim_pkg::T6, tim_pkg::B1, tim_pkg::B0);
            end
            default: c = '0;
        endcase
        if (add_ea && c.ok) begin
            c.clk = c.clk + CW'(q.ea_clk);
            c.rd = c.rd + BW'(q.ea_rd);
            c.wr = c.wr + BW'(q.ea_wr);
        end
        return c;
    endfunction : entry_cost

    tim_pkg::cost_t req_cost;
    tim_pkg::cost_t cost_reg;
    logic busy_reg;
    logic [CW-1:0] clk_left_reg;
    logic [BW-1:0] rd_left_reg;
    logic [BW-1:0] wr_left_reg;
    logic [1:0] slot_reg;
    logic rd_pulse_reg;
    logic wr_pulse_reg;
    logic done_reg;
    logic err_reg;
    logic accept;
    logic slot_start;
    logic rd_issue;
    logic wr_issue;
    logic last;

    assign req_cost = entry_cost(REQ_I);
    assign accept = REQ_VALID_I && !busy_reg;
    assign slot_start = busy_reg && slot_reg == tim_pkg::SLOT_FIRST;
    assign rd_issue = slot_start && rd_left_reg != tim_pkg::B0;
    assign wr_issue = slot_start && rd_left_reg == tim_pkg::B0 && wr_left_reg != tim_pkg::B0;
    assign last = busy_reg && clk_left_reg == tim_pkg::T1;

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            busy_reg <= 1'b0;
        end else if (accept && req_cost.ok) begin
            busy_reg <= 1'b1;
        end else if (last) begin
            busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            clk_left_reg <= '0;
            rd_left_reg <= '0;
            wr_left_reg <= '0;
            slot_reg <= tim_pkg::SLOT_FIRST;
        end else if (accept && req_cost.ok) begin
            clk_left_reg <= req_cost.clk;
            rd_left_reg <= req_cost.rd;
            wr_left_reg <= req_cost.wr;
            slot_reg <= tim_pkg::SLOT_FIRST;
        end else if (busy_reg) begin
            clk_left_reg <= clk_left_reg - tim_pkg::T1;
            slot_reg <= slot_reg + tim_pkg::SLOT_STEP;
            if (rd_issue) begin
                rd_left_reg <= rd_left_reg - tim_pkg::B1;
            end
            if (wr_issue) begin
                wr_left_reg <= wr_left_reg - tim_pkg::B1;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            rd_pulse_reg <= 1'b0;
            wr_pulse_reg <= 1'b0;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            rd_pulse_reg <= rd_issue;
            wr_pulse_reg <= wr_issue;
            done_reg <= last;
            err_reg <= accept && !req_cost.ok;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            cost_reg <= '0;
        end else if (accept && req_cost.ok) begin
            cost_reg <= req_cost;
        end
    end

    assign REQ_READY_O = !busy_reg;
    assign BUSY_O = busy_reg;
    assign RD_CYCLE_O = rd_pulse_reg;
    assign WR_CYCLE_O = wr_pulse_reg;
    assign DONE_O = done_reg;
    assign ERR_O = err_reg;
    assign COST_O = cost_reg;

    // Helper counters seen only by the checks below.
    logic [CW-1:0] run_cnt;
    logic [BW-1:0] rd_seen;
    logic [BW-1:0] wr_seen;
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I || accept) begin
            run_cnt <= '0;
            rd_seen <= '0;
            wr_seen <= '0;
        end else if (busy_reg) begin
            run_cnt <= run_cnt + tim_pkg::T1;
            rd_seen <= rd_seen + BW'(rd_issue);
            wr_seen <= wr_seen + BW'(wr_issue);
        end
    end

    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    sequence s_start;
        accept && req_cost.ok;
    endsequence
    sequence s_run;
        busy_reg [*4];
    endsequence

    a_least_run: assert property (s_start |=> s_run)
        else $error("Instruction ran fewer than four clocks.");
    a_clock_total: assert property (done_reg |-> run_cnt == cost_reg.clk)
        else $error("Clock count differs from the entry.");
    a_read_total: assert property (done_reg |-> rd_seen == cost_reg.rd)
        else $error("Read cycle count differs from the entry.");
    a_write_total: assert property (done_reg |-> wr_seen == cost_reg.wr)
        else $error("Write cycle count differs from the entry.");
    a_bus_slot: assert property (RD_CYCLE_O |=> (!RD_CYCLE_O && !WR_CYCLE_O) [*3])
        else $error("Bus access shorter than four clocks.");
    a_fill_memory: assert property (s_start ##0 (REQ_I.op == tim_pkg::OP_ZERO_FILL
        && REQ_I.mem && REQ_I.long_sz) |=> cost_reg.clk == tim_pkg::T12
        + CW'($past(REQ_I.ea_clk)) && cost_reg.wr == tim_pkg::B2
        + BW'($past(REQ_I.ea_wr)))
        else $error("Long memory clear cost wrong.");
    a_shift_reg: assert property (s_start ##0 (REQ_I.op == tim_pkg::OP_SHIFT_ROTATE
        && !REQ_I.mem && !REQ_I.long_sz) |=> cost_reg.clk == tim_pkg::T6
        + CW'($past(REQ_I.n)) * tim_pkg::STEP2)
        else $error("Register shift cost wrong.");
    a_branch_word: assert property (s_start ##0 (REQ_I.op == tim_pkg::OP_COND_BRANCH
        && !REQ_I.cond && REQ_I.word_disp) |=> cost_reg.clk == tim_pkg::T12
        && cost_reg.rd == tim_pkg::B2)
        else $error("Untaken word branch cost wrong.");
    a_multi_store: assert property (s_start ##0 (REQ_I.op == tim_pkg::OP_MULTI_STORE
        && REQ_I.long_sz) |=> cost_reg.wr == BW'($past(REQ_I.n)) * tim_pkg::B2)
        else $error("Long multi-register store write count wrong.");
    a_multi_prec: assert property (s_start ##0 (REQ_I.op == tim_pkg::OP_ADD_EXT
        && REQ_I.mem && REQ_I.long_sz) |=> cost_reg.clk == tim_pkg::T30
        && cost_reg.rd == tim_pkg::B5)
        else $error("Extended add memory cost took address time.");
endmodule : cpu_instr_timing
`default_nettype wire

// [common/tim_pkg.sv]
`default_nettype none
package tim_pkg;
    localparam int CNT_W = 6;
    localparam int CLK_W = 10;
    localparam int BUS_W = 6;

    typedef enum logic [4:0] {
        OP_ZERO_FILL, OP_ARITH_COMPL, OP_COMPL_EXT, OP_INVERT,
        OP_DEC_NEGATE, OP_COND_SET, OP_PROBE_MARK, OP_CMP_ZERO,
        OP_SHIFT_ROTATE, OP_BIT_TOGGLE, OP_BIT_RESET, OP_BIT_SET, OP_BIT_PROBE,
        OP_COND_BRANCH, OP_ALWAYS_JUMP, OP_CALL_REL, OP_DEC_LOOP,
        OP_TRANSFER, OP_CALL_EA, OP_LOAD_EA, OP_PUSH_EA,
        OP_MULTI_LOAD, OP_MULTI_STORE,
        OP_ADD_EXT, OP_SUB_EXT, OP_PAIR_CMP, OP_DEC_ADD, OP_DEC_SUB
    } op_t;

    typedef enum logic [2:0] {
        EA_IND, EA_POSTINC, EA_PREDEC, EA_DISP, EA_ABSL
    } ea_t;

    typedef struct packed {
        op_t op;
        logic long_sz;
        logic mem;
        logic static_bit;
        logic cond;
        logic word_disp;
        logic expired;
        ea_t ea;
        logic [CNT_W-1:0] n;
        logic [CNT_W-1:0] ea_clk;
        logic [2:0] ea_rd;
        logic [2:0] ea_wr;
    } req_t;

    typedef struct packed {
        logic ok;
        logic [CLK_W-1:0] clk;
        logic [BUS_W-1:0] rd;
        logic [BUS_W-1:0] wr;
    } cost_t;

    localparam logic [CLK_W-1:0] T1 = 10'h001;
    localparam logic [CLK_W-1:0] T4 = 10'h004;
    localparam logic [CLK_W-1:0] T6 = 10'h006;
    localparam logic [CLK_W-1:0] T8 = 10'h008;
    localparam logic [CLK_W-1:0] T10 = 10'h00a;
    localparam logic [CLK_W-1:0] T12 = 10'h00c;
    localparam logic [CLK_W-1:0] T14 = 10'h00e;
    localparam logic [CLK_W-1:0] T16 = 10'h010;
    localparam logic [CLK_W-1:0] T18 = 10'h012;
    localparam logic [CLK_W-1:0] T20 = 10'h014;
    localparam logic [CLK_W-1:0] T30 = 10'h01e;
    localparam logic [CLK_W-1:0] STEP2 = 10'h002;
    localparam logic [BUS_W-1:0] B0 = 6'h00;
    localparam logic [BUS_W-1:0] B1 = 6'h01;
    localparam logic [BUS_W-1:0] B2 = 6'h02;
    localparam logic [BUS_W-1:0] B3 = 6'h03;
    localparam logic [BUS_W-1:0] B4 = 6'h04;
    localparam logic [BUS_W-1:0] B5 = 6'h05;
    localparam logic [1:0] SLOT_FIRST = 2'h0;
    localparam logic [1:0] SLOT_STEP = 2'h1;
endpackage : tim_pkg
`default_nettype wire

// [testbench/bus_slave_model.sv]
`default_nettype none
module bus_slave_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic busy_i,
    input wire logic rd_i,
    input wire logic wr_i,
    output logic [15:0] rd_count_o,
    output logic [15:0] wr_count_o,
    output logic order_bad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_seen_reg;
    // Each slot marker is one zero-wait access that completes in its four clocks.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rd_count_o <= 16'h0000;
            wr_count_o <= 16'h0000;
        end else begin
            rd_count_o <= rd_count_o + {15'h0000, rd_i};
            wr_count_o <= wr_count_o + {15'h0000, wr_i};
        end
    end
    // A read after a write within one instruction, or both at once, is flagged.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wr_seen_reg <= 1'b0;
            order_bad_o <= 1'b0;
        end else begin
            wr_seen_reg <= busy_i && (wr_seen_reg || wr_i);
            if ((rd_i && wr_seen_reg) || (rd_i && wr_i)) begin
                order_bad_o <= 1'b1;
            end
        end
    end
endmodule : bus_slave_model
`default_nettype wire

// [testbench/cpu_instr_timing_bench.sv]
`default_nettype none
module cpu_instr_timing_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        tim_pkg::op_t op;
        logic [5:0] f;
        logic [2:0] ea;
        logic [5:0] n;
        logic [1:0] e;
        logic [9:0] c;
        logic [5:0] r;
        logic [5:0] w;
    } row_t;
    logic CLK_I = 1'b0;
    logic RESETN_I = 1'b0;
    logic REQ_VALID_I = 1'b0;
    tim_pkg::req_t REQ_I = '0;
    logic REQ_READY_O, BUSY_O, RD_CYCLE_O, WR_CYCLE_O, DONE_O, ERR_O, order_bad;
    tim_pkg::cost_t COST_O;
    logic [15:0] rd_count, wr_count;
    int err_count = 0;
    int checked = 0;
    row_t rows[$];
    always #20 CLK_I = ~CLK_I;
    cpu_instr_timing DUT (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .REQ_VALID_I(REQ_VALID_I),
        .REQ_I(REQ_I), .REQ_READY_O(REQ_READY_O), .BUSY_O(BUSY_O), .RD_CYCLE_O(RD_CYCLE_O),
        .WR_CYCLE_O(WR_CYCLE_O), .DONE_O(DONE_O), .ERR_O(ERR_O), .COST_O(COST_O));
    bus_slave_model mem_side (.clk_i(CLK_I), .resetn_i(RESETN_I), .busy_i(BUSY_O),
        .rd_i(RD_CYCLE_O), .wr_i(WR_CYCLE_O), .rd_count_o(rd_count), .wr_count_o(wr_count),
        .order_bad_o(order_bad));
    task automatic close_out();
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            err_count++;
        end
    endtask : chk
    // Drives a request at a falling edge; valid stays up until the caller drops it.
    task automatic put(input row_t r);
        @(negedge CLK_I);
        REQ_I.op = r.op;
        {REQ_I.long_sz, REQ_I.mem, REQ_I.static_bit, REQ_I.cond, REQ_I.word_disp,
            REQ_I.expired} = r.f;
        REQ_I.ea = tim_pkg::ea_t'(r.ea);
        REQ_I.n = r.n;
        REQ_I.ea_clk = {2'h0, r.e, 2'h0};
        REQ_I.ea_rd = {1'b0, r.e};
        REQ_I.ea_wr = 3'h0;
        REQ_VALID_I = 1'b1;
    endtask : put
    task automatic wait_done(output int k);
        k = 0;
        for (int i = 0; i < 200 && DONE_O !== 1'b1; i++) begin
            if (BUSY_O === 1'b1) k++;
            @(negedge CLK_I);
        end
        if (DONE_O !== 1'b1) begin
            err_count++;
            close_out();
        end
    endtask : wait_done
    task automatic run(input row_t r);
        int k;
        logic [15:0] r0, w0;
        r0 = rd_count;
        w0 = wr_count;
        put(r);
        @(negedge CLK_I);
        REQ_VALID_I = 1'b0;
        chk(32'(COST_O), 32'({1'b1, r.c, r.r, r.w}));
        wait_done(k);
        chk(32'(k), 32'(r.c));
        chk(32'(rd_count - r0), 32'(r.r));
        chk(32'(wr_count - w0), 32'(r.w));
    endtask : run
    initial begin
        int k;
        rows = '{
            '{tim_pkg::OP_ZERO_FILL, 6'h00, 0, 0, 0, 4, 1, 0},
            '{tim_pkg::OP_ZERO_FILL, 6'h30, 0, 0, 0, 12, 1, 2},
            '{tim_pkg::OP_INVERT, 6'h20, 0, 0, 0, 6, 1, 0},
            '{tim_pkg::OP_ARITH_COMPL, 6'h10, 0, 0, 0, 8, 1, 1},
            '{tim_pkg::OP_COMPL_EXT, 6'h30, 0, 0, 0, 12, 1, 2},
            '{tim_pkg::OP_ZERO_FILL, 6'h10, 0, 0, 1, 12, 2, 1},
            '{tim_pkg::OP_DEC_NEGATE, 6'h00, 0, 0, 0, 6, 1, 0},
            '{tim_pkg::OP_COND_SET, 6'h00, 0, 0, 0, 4, 1, 0},
            '{tim_pkg::OP_COND_SET, 6'h04, 0, 0, 0, 6, 1, 0},
            '{tim_pkg::OP_PROBE_MARK, 6'h10, 0, 0, 0, 10, 1, 1},
            '{tim_pkg::OP_CMP_ZERO, 6'h30, 0, 0, 0, 4, 1, 0},
            '{tim_pkg::OP_SHIFT_ROTATE, 6'h00, 0, 3, 0, 12, 1, 0},
            '{tim_pkg::OP_SHIFT_ROTATE, 6'h20, 0, 5, 0, 18, 1, 0},
            '{tim_pkg::OP_SHIFT_ROTATE, 6'h10, 0, 0, 0, 8, 1, 1},
            '{tim_pkg::OP_BIT_RESET, 6'h20, 0, 0, 0, 10, 1, 0},
            '{tim_pkg::OP_BIT_RESET, 6'h28, 0, 0, 0, 14, 2, 0},
            '{tim_pkg::OP_BIT_PROBE, 6'h28, 0, 0, 0, 10, 2, 0},
            '{tim_pkg::OP_BIT_TOGGLE, 6'h18, 0, 0, 0, 12, 2, 1},
            '{tim_pkg::OP_BIT_PROBE, 6'h10, 0, 0, 0, 4, 1, 0},
            '{tim_pkg::OP_BIT_SET, 6'h20, 0, 0, 0, 8, 1, 0},
            '{tim_pkg::OP_COND_BRANCH, 6'h04, 0, 0, 0, 10, 2, 0},
            '{tim_pkg::OP_COND_BRANCH, 6'h00, 0, 0, 0, 8, 1, 0},
            '{tim_pkg::OP_COND_BRANCH, 6'h02, 0, 0, 0, 12, 2, 0},
            '{tim_pkg::OP_ALWAYS_JUMP, 6'h00, 0, 0, 0, 10, 2, 0},
            '{tim_pkg::OP_CALL_REL, 6'h00, 0, 0, 0, 18, 2, 2},
            '{tim_pkg::OP_DEC_LOOP, 6'h04, 0, 0, 0, 12, 2, 0},
            '{tim_pkg::OP_DEC_LOOP, 6'h00, 0, 0, 0, 10, 2, 0},
            '{tim_pkg::OP_TRANSFER, 6'h00, 0, 0, 0, 8, 2, 0},
            '{tim_pkg::OP_CALL_EA, 6'h00, 4, 0, 0, 20, 3, 2},
            '{tim_pkg::OP_LOAD_EA, 6'h00, 0, 0, 0, 4, 1, 0},
            '{tim_pkg::OP_PUSH_EA, 6'h00, 3, 0, 0, 16, 2, 2},
            '{tim_pkg::OP_TRANSFER, 6'h00, 3, 0, 0, 10, 2, 0},
            '{tim_pkg::OP_LOAD_EA, 6'h00, 4, 0, 0, 12, 3, 0},
            '{tim_pkg::OP_MULTI_LOAD, 6'h00, 0, 2, 0, 20, 5, 0},
            '{tim_pkg::OP_MULTI_LOAD, 6'h20, 1, 3, 0, 36, 9, 0},
            '{tim_pkg::OP_MULTI_STORE, 6'h00, 2, 2, 0, 16, 2, 2},
            '{tim_pkg::OP_MULTI_STORE, 6'h20, 0, 3, 0, 32, 2, 6},
            '{tim_pkg::OP_MULTI_LOAD, 6'h00, 3, 1, 0, 20, 5, 0},
            '{tim_pkg::OP_MULTI_STORE, 6'h20, 4, 1, 0, 24, 4, 2},
            '{tim_pkg::OP_ADD_EXT, 6'h20, 0, 0, 0, 8, 1, 0},
            '{tim_pkg::OP_SUB_EXT, 6'h30, 0, 0, 2, 30, 5, 2},
            '{tim_pkg::OP_PAIR_CMP, 6'h10, 0, 0, 0, 12, 3, 0},
            '{tim_pkg::OP_PAIR_CMP, 6'h30, 0, 0, 0, 20, 5, 0},
            '{tim_pkg::OP_DEC_ADD, 6'h00, 0, 0, 0, 6, 1, 0},
            '{tim_pkg::OP_DEC_SUB, 6'h10, 0, 0, 0, 18, 3, 1}};
        repeat (5) @(negedge CLK_I);
        chk(32'(REQ_READY_O), 32'h1);
        chk(32'(COST_O), 32'h0);
        RESETN_I = 1'b1;
        foreach (rows[i]) begin
            run(rows[i]);
            $display("test %0d done", i);
        end
        // Long shift on memory has no timing entry and must leave the cost alone.
        put('{tim_pkg::OP_SHIFT_ROTATE, 6'h30, 0, 1, 0, 0, 0, 0});
        @(negedge CLK_I);
        REQ_VALID_I = 1'b0;
        chk(32'(ERR_O), 32'h1);
        chk(32'(BUSY_O), 32'h0);
        chk(32'(COST_O), 32'({1'b1, 10'h012, 6'h03, 6'h01}));
        $display("test illegal done");
        // Valid held high: refused while busy, taken in the done cycle.
        put('{tim_pkg::OP_ZERO_FILL, 6'h00, 0, 0, 0, 4, 1, 0});
        put('{tim_pkg::OP_DEC_LOOP, 6'h01, 0, 0, 0, 14, 3, 0});
        wait_done(k);
        chk(32'(k), 32'h4);
        chk(32'(REQ_READY_O), 32'h1);
        @(negedge CLK_I);
        REQ_VALID_I = 1'b0;
        chk(32'(COST_O), 32'({1'b1, 10'h00e, 6'h03, 6'h00}));
        $display("test back to back done");
        repeat (3) @(negedge CLK_I);
        RESETN_I = 1'b0;
        repeat (2) @(negedge CLK_I);
        chk(32'(BUSY_O), 32'h0);
        chk(32'(COST_O), 32'h0);
        RESETN_I = 1'b1;
        run(rows[0]);
        chk(32'(order_bad), 32'h0);
        $display("test reset done");
        close_out();
    end
endmodule : cpu_instr_timing_bench
`default_nettype wire
